// ### hw/cpt_core.sv
// The implementer's own choice: the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module cpt_core #(
  parameter logic [7:0] GPR_TOP = 8'h2f
) (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire cpt_pkg::cpt_apb_req_t apb_i,
  output cpt_pkg::cpt_apb_rsp_t apb_o,
  output logic [cpt_pkg::PC_W-1:0] prog_addr,
  input wire logic [cpt_pkg::IW-1:0] prog_data,
  input wire logic [7:0] irq_event,
  output logic [3:0] phase
);
  import cpt_pkg::*;

  localparam int GPR_N = int'(GPR_TOP) - int'(GPR_BASE) + 1;

  generate
    if (GPR_TOP < GPR_BASE || GPR_TOP > 8'h7f)
    begin : g_bad
      $error("GPR_TOP outside the bank");
    end
  endgenerate

  typedef struct packed {
    logic [3:0] ph;
    logic run;
    logic started;
    logic [PC_W-1:0] pc;
    logic [IW-1:0] ir;
    logic irv;
    logic br;
    logic [PC_W-1:0] tgt;
    logic [7:0] opnd;
    logic [7:0] w;
    logic [7:0] stat;
    logic [7:0] ind_ptr;
    logic [7:0] pch;
    logic [7:0] intc;
    logic [7:0] pir;
    logic [N_PLAIN-1:0][7:0] plain;
    logic [GPR_N-1:0][7:0] gpr;
    logic [31:0] prdata;
    logic done;
    logic err;
  } cpt_state_t;

  cpt_state_t r;
  cpt_state_t n;
  cpt_map_t m_op;
  cpt_map_t m_bus;
  logic [8:0] res;
  logic [7:0] bmask;
  logic [7:0] bidx;
  logic [31:0] own_rd;
  logic wr_f;
  logic wr_w;
  logic fz;
  logic fc;
  logic jump;
  logic skip;
  logic cnt_lo_jump;
  logic flush;
  logic own;
  logic own_ok;
  logic slot;

  // ----------------------------------------
  // Address decode
  // ----------------------------------------
  function automatic cpt_map_t map_addr(input logic [7:0] a_in, input logic [7:0] ptr);
    cpt_map_t m;
    logic [7:0] a;
    m.kind = K_NONE;
    m.idx = 8'h00;
    a = (a_in[6:0] == 7'h00) ? ptr : a_in;
    if (a[7] && a[6:0] >= MIRROR_LO && {1'b0, a[6:0]} <= GPR_TOP)
      a = {1'b0, a[6:0]};
    if (!a[7] && a >= GPR_BASE && a <= GPR_TOP)
    begin
      m.kind = K_GPR;
      m.idx = a - GPR_BASE;
    end
    else
    begin
      case (a)
        A_TMR: m = '{K_PLAIN, 8'h00};
        A_CNT_LO, A_CNT_LO | BANK1: m.kind = K_CNT_LO;
        A_STAT, A_STAT | BANK1: m.kind = K_STAT;
        A_PTR, A_PTR | BANK1: m.kind = K_PTR;
        A_PORT_A: m = '{K_PLAIN, 8'h01};
        A_PORT_B: m = '{K_PLAIN, 8'h02};
        A_ADC0: m = '{K_PLAIN, 8'h03};
        A_RESULT, A_RESULT | BANK1: m = '{K_PLAIN, 8'h04};
        A_PCH, A_PCH | BANK1: m.kind = K_PCH;
        A_INTC, A_INTC | BANK1: m.kind = K_INTC;
        A_PIR: m.kind = K_PIR;
        A_OPT: m = '{K_PLAIN, 8'h05};
        A_DIR_A: m = '{K_PLAIN, 8'h06};
        A_DIR_B: m = '{K_PLAIN, 8'h07};
        A_PWR_CTL: m = '{K_PLAIN, 8'h08};
        A_ADC1: m = '{K_PLAIN, 8'h09};
        default: m.kind = K_NONE;
      endcase
    end
    return m;
  endfunction

  function automatic logic [7:0] rd(input cpt_state_t s, input cpt_map_t m);
    case (m.kind)
      K_GPR: rd = s.gpr[m.idx];
      K_CNT_LO: rd = s.pc[7:0];
      K_STAT: rd = s.stat;
      K_PTR: rd = s.ind_ptr;
      K_PCH: rd = s.pch;
      K_INTC: rd = s.intc;
      K_PIR: rd = s.pir;
      K_PLAIN: rd = s.plain[m.idx[3:0]];
      default: rd = 8'h00;
    endcase
  endfunction

  // Writes to the counter low byte are branches, handled by the core only
  function automatic cpt_state_t wr(input cpt_state_t s_in, input cpt_map_t m, input logic [7:0] v);
    cpt_state_t s;
    s = s_in;
    case (m.kind)
      K_GPR: s.gpr[m.idx] = v;
      K_STAT: s.stat = (v & STAT_WMASK) | (s_in.stat & ~STAT_WMASK);
      K_PTR: s.ind_ptr = v;
      K_PCH: s.pch = v & PCH_MASK;
      K_INTC: s.intc = v;
      K_PIR: s.pir = v;
      K_PLAIN: s.plain[m.idx[3:0]] = v;
      default: s = s_in;
    endcase
    return s;
  endfunction

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb
  begin
    n = r;
    m_op = map_addr({r.stat[STAT_BANK], r.ir[6:0]}, r.ind_ptr);
    m_bus = map_addr(apb_i.paddr[FILE_LSB+7:FILE_LSB], r.ind_ptr);
    res = 9'h000;
    wr_f = 1'b0;
    wr_w = 1'b0;
    fz = 1'b0;
    fc = 1'b0;
    jump = 1'b0;
    skip = 1'b0;
    bidx = {5'h00, r.ir[9:7]};
    bmask = 8'h01 << r.ir[9:7];
    case (r.ir[13:12])
      GRP_BYTE:
      begin
        case (r.ir[11:8])
          OP_MOVWF:
          begin
            res = {1'b0, r.w};
            wr_f = r.ir[7];
          end
          OP_CLR:
          begin
            wr_f = r.ir[7];
            wr_w = !r.ir[7];
            fz = 1'b1;
          end
          OP_ADD:
          begin
            res = {1'b0, r.opnd} + {1'b0, r.w};
            wr_f = r.ir[7];
            wr_w = !r.ir[7];
            fz = 1'b1;
            fc = 1'b1;
          end
          OP_MOVF:
          begin
            res = {1'b0, r.opnd};
            wr_f = r.ir[7];
            wr_w = !r.ir[7];
            fz = 1'b1;
          end
          OP_INC:
          begin
            res = {1'b0, r.opnd} + 9'h001;
            wr_f = r.ir[7];
            wr_w = !r.ir[7];
            fz = 1'b1;
          end
          default: res = 9'h000;
        endcase
      end
      GRP_BIT:
      begin
        case (r.ir[11:10])
          OP_BCLR:
          begin
            res = {1'b0, r.opnd & ~bmask};
            wr_f = 1'b1;
          end
          OP_BSET:
          begin
            res = {1'b0, r.opnd | bmask};
            wr_f = 1'b1;
          end
          OP_SKC: skip = !r.opnd[bidx[2:0]];
          OP_SKS: skip = r.opnd[bidx[2:0]];
          default: skip = 1'b0;
        endcase
      end
      GRP_JUMP: jump = 1'b1;
      GRP_LIT:
      begin
        if (r.ir[11:10] == OP_MOVLW)
        begin
          res = {1'b0, r.ir[7:0]};
          wr_w = 1'b1;
        end
      end
      default: jump = 1'b0;
    endcase
    cnt_lo_jump = wr_f && (m_op.kind == K_CNT_LO);
    flush = r.irv && (jump || skip || cnt_lo_jump);

    // ----------------------------------------
    // Phase and pipeline
    // ----------------------------------------
    if (r.run)
    begin
      n.ph = {r.ph[2:0], r.ph[3]};
      if (r.ph[0])
      begin
        if (r.started)
        begin
          n.pc = r.br ? r.tgt : r.pc + PC_ONE;
          n.br = 1'b0;
        end
        else
          n.started = 1'b1;
      end
      if (r.ph[1] && r.irv)
        n.opnd = rd(r, m_op);
      if (r.ph[3])
      begin
        if (r.irv)
        begin
          if (wr_w)
            n.w = res[7:0];
          if (cnt_lo_jump)
          begin
            n.tgt = {r.pch[4:0], res[7:0]};
            n.br = 1'b1;
          end
          else if (wr_f)
            n = wr(n, m_op, res[7:0]);
          if (fz)
            n.stat[STAT_Z] = (res[7:0] == 8'h00);
          if (fc)
            n.stat[STAT_C] = res[8];
          if (jump)
          begin
            n.tgt = {r.pch[4:3], r.ir[10:0]};
            n.br = 1'b1;
          end
        end
        n.ir = prog_data;
        n.irv = r.started && !flush;
      end
    end

    // ----------------------------------------
    // Bus slave
    // ----------------------------------------
    // While running, bus slots sit in phase two, where the core only reads data memory, and bus writes land in phase three; halted, every cycle is a slot
    own = apb_i.paddr[OWN_BIT];
    case (apb_i.paddr[FILE_LSB+7:FILE_LSB])
      CTRL_IDX: own_rd = {31'h0, r.run};
      CSTAT_IDX: own_rd = {18'h0, r.irv, r.pc};
      WREG_IDX: own_rd = {24'h0, r.w};
      default: own_rd = 32'h0;
    endcase
    own_ok = apb_i.paddr[FILE_LSB+7:FILE_LSB] <= WREG_IDX;
    slot = r.ph[1] || !r.run;
    if (apb_i.psel && apb_i.penable)
    begin
      if (!r.done)
      begin
        if (slot)
        begin
          n.done = 1'b1;
          n.err = own && !own_ok;
          n.prdata = own ? own_rd : {24'h0, rd(r, m_bus)};
        end
      end
      else
      begin
        n.done = 1'b0;
        if (apb_i.pwrite && !r.err)
        begin
          if (!own)
            n = wr(n, m_bus, apb_i.pwdata[7:0]);
          else if (apb_i.paddr[FILE_LSB+7:FILE_LSB] == CTRL_IDX)
            n.run = apb_i.pwdata[0];
        end
      end
    end
    else
      n.done = 1'b0;

    // Set wins over any clear in the same cycle
    n.pir = n.pir | irq_event;
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
    begin
      r <= '0;
      r.ph <= PH_RESET;
      r.run <= CTRL_RUN_RESET;
      r.stat <= STAT_RESET;
    end
    else
      r <= n;
  end

  assign prog_addr = r.pc;
  assign phase = r.ph;
  assign apb_o.prdata = r.prdata;
  assign apb_o.pready = r.done;
  assign apb_o.pslverr = r.done && r.err;

endmodule
`default_nettype wire

// ### hw/cpt_pkg.sv
// Behaviour
// - Input clock divided by four into rotating one-hot phases one to four.
// - Program counter advances at phase one; fetched word latched at phase four.
// - Next fetch overlaps execution, giving one instruction per cycle.
// - Any change of program counter discards the fetched word, executing a no-operation.
// - Operand read in phase two, result written back in phase four.
// - Status bit five picks bank one when set, bank zero when clear.
// - Each bank spans 128 addresses; special registers low, general storage above.
// - Frequently used special registers appear in both banks as one register.
// - Access is direct or through the pointer; offset zero is no register.
// - Peripheral flags set on their event regardless of any enable.
package cpt_pkg;

  // ----------------------------------------
  // Core widths and reset values
  // ----------------------------------------
  localparam int PC_W = 13;
  localparam int IW = 14;
  localparam logic [PC_W-1:0] PC_ONE = 13'h0001;
  localparam logic [3:0] PH_RESET = 4'h1;
  localparam logic [7:0] STAT_RESET = 8'h18;
  localparam logic CTRL_RUN_RESET = 1'b1;

  // ----------------------------------------
  // File map offsets
  // ----------------------------------------
  localparam logic [7:0] BANK1 = 8'h80;
  localparam logic [7:0] A_TMR = 8'h01;
  localparam logic [7:0] A_CNT_LO = 8'h02;
  localparam logic [7:0] A_STAT = 8'h03;
  localparam logic [7:0] A_PTR = 8'h04;
  localparam logic [7:0] A_PORT_A = 8'h05;
  localparam logic [7:0] A_PORT_B = 8'h06;
  localparam logic [7:0] A_ADC0 = 8'h08;
  localparam logic [7:0] A_RESULT = 8'h09;
  localparam logic [7:0] A_PCH = 8'h0a;
  localparam logic [7:0] A_INTC = 8'h0b;
  localparam logic [7:0] A_PIR = 8'h0c;
  localparam logic [7:0] A_OPT = 8'h81;
  localparam logic [7:0] A_DIR_A = 8'h85;
  localparam logic [7:0] A_DIR_B = 8'h86;
  localparam logic [7:0] A_PWR_CTL = 8'h87;
  localparam logic [7:0] A_ADC1 = 8'h88;
  localparam logic [7:0] GPR_BASE = 8'h0d;
  localparam logic [6:0] MIRROR_LO = 7'h0c;
  localparam int N_PLAIN = 10;

  // ----------------------------------------
  // Field positions and masks
  // ----------------------------------------
  localparam int STAT_BANK = 5;
  localparam int STAT_Z = 2;
  localparam int STAT_C = 0;
  localparam logic [7:0] STAT_WMASK = 8'he7;
  localparam logic [7:0] PCH_MASK = 8'h1f;
  localparam int INTC_GLOBAL_EN = 7;

  // ----------------------------------------
  // Opcodes
  // ----------------------------------------
  localparam logic [1:0] GRP_BYTE = 2'b00;
  localparam logic [1:0] GRP_BIT = 2'b01;
  localparam logic [1:0] GRP_JUMP = 2'b10;
  localparam logic [1:0] GRP_LIT = 2'b11;
  localparam logic [3:0] OP_MOVWF = 4'h0;
  localparam logic [3:0] OP_CLR = 4'h1;
  localparam logic [3:0] OP_ADD = 4'h7;
  localparam logic [3:0] OP_MOVF = 4'h8;
  localparam logic [3:0] OP_INC = 4'ha;
  localparam logic [1:0] OP_BCLR = 2'b00;
  localparam logic [1:0] OP_BSET = 2'b01;
  localparam logic [1:0] OP_SKC = 2'b10;
  localparam logic [1:0] OP_SKS = 2'b11;
  localparam logic [1:0] OP_MOVLW = 2'b00;

  // ----------------------------------------
  // Bus window
  // ----------------------------------------
  localparam int APB_AW = 12;
  localparam int FILE_LSB = 2;
  localparam int OWN_BIT = 10;
  localparam logic [7:0] CTRL_IDX = 8'h00;
  localparam logic [7:0] CSTAT_IDX = 8'h01;
  localparam logic [7:0] WREG_IDX = 8'h02;

  typedef enum logic [3:0] {
    K_NONE, K_GPR, K_CNT_LO, K_STAT, K_PTR, K_PCH, K_INTC, K_PIR, K_PLAIN
  } cpt_kind_t;

  typedef struct packed {
    cpt_kind_t kind;
    logic [7:0] idx;
  } cpt_map_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [APB_AW-1:0] paddr;
    logic [31:0] pwdata;
  } cpt_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } cpt_apb_rsp_t;

endpackage

// ### verif/cpt_prog_mem.sv
`timescale 1ns/1ps
`default_nettype none
module cpt_prog_mem
  import cpt_pkg::*;
(
  input wire logic [cpt_pkg::PC_W-1:0] prog_addr,
  output logic [cpt_pkg::IW-1:0] prog_data
);
  // ----------------------------------------
  // Fixed test program
  // ----------------------------------------
  // Word answers in the same cycle as its address, so the latch sees it settled
  always_comb
  begin
    case (prog_addr)
      13'h0000: prog_data = 14'h305a;
      13'h0001: prog_data = 14'h00a0;
      13'h0002: prog_data = 14'h2804;
      13'h0003: prog_data = 14'h30ff;
      13'h0004: prog_data = 14'h00a1;
      13'h0005: prog_data = 14'h1683;
      13'h0006: prog_data = 14'h00a2;
      default: prog_data = 14'h2807;
    endcase
  end
endmodule
`default_nettype wire

// ### verif/cpt_core_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module cpt_core_assertions
  import cpt_pkg::*;
#(
  parameter logic [7:0] GPR_TOP = 8'h2f
) (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire cpt_pkg::cpt_apb_req_t apb_i,
  input wire cpt_pkg::cpt_apb_rsp_t apb_o,
  input wire logic [cpt_pkg::PC_W-1:0] prog_addr,
  input wire logic [cpt_pkg::IW-1:0] prog_data,
  input wire logic [7:0] irq_event,
  input wire logic [3:0] phase
);
  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  a_phase_onehot: assert property ($onehot(phase)) else $error("phase not one-hot");
  a_phase_rotate: assert property (!$stable(phase) |-> phase == {$past(phase[2:0]), $past(phase[3])})
    else $error("phase skipped a step");
  a_pc_phase: assert property (!$stable(prog_addr) |-> $past(phase) == 4'h1)
    else $error("program address moved outside phase one");
  a_reset_start: assert property ($rose(rstn) |-> phase == 4'h1 && prog_addr == '0)
    else $error("bad state after reset");
  a_ready_once: assert property (apb_o.pready |=> !apb_o.pready) else $error("pready longer than one cycle");
  a_ready_cause: assert property (apb_o.pready |-> $past(apb_i.psel && apb_i.penable))
    else $error("pready without access");
  a_ready_bound: assert property (apb_i.psel && apb_i.penable && !apb_o.pready |-> ##[1:5] apb_o.pready)
    else $error("access not answered");
  a_err_unmapped: assert property (apb_o.pready |->
    apb_o.pslverr == ($past(apb_i.paddr[OWN_BIT]) && $past(apb_i.paddr[9:2]) > 8'h02))
    else $error("pslverr wrong");
  a_file_upper: assert property (apb_o.pready && !$past(apb_i.paddr[OWN_BIT]) |-> apb_o.prdata[31:8] == '0)
    else $error("file read upper bits set");
  c_slverr: cover property (apb_o.pready && apb_o.pslverr);
endmodule

bind cpt_core cpt_core_assertions #(.GPR_TOP(GPR_TOP)) cpt_core_assertions_inst (
  .ref_clk(ref_clk),
  .rstn(rstn),
  .apb_i(apb_i),
  .apb_o(apb_o),
  .prog_addr(prog_addr),
  .prog_data(prog_data),
  .irq_event(irq_event),
  .phase(phase)
);
`default_nettype wire

// ### verif/test_core_phase_timing_and_banked_data_memory.sv
`timescale 1ns/1ps
`default_nettype none
module test_core_phase_timing_and_banked_data_memory;
  import cpt_pkg::*;
  logic ref_clk = 1'b0;
  logic rstn = 1'b0;
  cpt_apb_req_t apb_i = '0;
  cpt_apb_rsp_t apb_o;
  logic [PC_W-1:0] prog_addr;
  logic [IW-1:0] prog_data;
  logic [7:0] irq_event = '0;
  logic [3:0] phase;
  int n_errors = 0;
  int checks_done = 0;
  logic [31:0] rd;
  logic err;
  logic [PC_W-1:0] pa;

  always #5 ref_clk = ~ref_clk;

  cpt_core cpt_core_inst (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .apb_i(apb_i),
    .apb_o(apb_o),
    .prog_addr(prog_addr),
    .prog_data(prog_data),
    .irq_event(irq_event),
    .phase(phase)
  );

  cpt_prog_mem cpt_prog_mem_inst (
    .prog_addr(prog_addr),
    .prog_data(prog_data)
  );

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic stop_test;
    if (n_errors == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      n_errors++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask

  // Waits on pready only; the slot timing is the design's business
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge ref_clk);
    apb_i.psel <= 1'b1;
    apb_i.penable <= 1'b0;
    apb_i.pwrite <= w;
    apb_i.paddr <= a;
    apb_i.pwdata <= wd;
    @(posedge ref_clk);
    apb_i.penable <= 1'b1;
    do
    begin
      @(posedge ref_clk);
      n++;
    end
    while (apb_o.pready !== 1'b1 && n < 20);
    if (apb_o.pready !== 1'b1)
      n_errors++;
    rd = apb_o.prdata;
    err = apb_o.pslverr;
    apb_i.psel <= 1'b0;
    apb_i.penable <= 1'b0;
  endtask

  task automatic rdc(input string name, input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(name, rd, exp);
  endtask

  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial
  begin
    repeat (8) @(posedge ref_clk);
    rstn <= 1'b1;
    repeat (80) @(posedge ref_clk);
    rdc("gpr 20", 12'h080, 32'h5a);
    rdc("gpr 21", 12'h084, 32'h5a);
    rdc("work reg", 12'h408, 32'h5a);
    rdc("gpr 22", 12'h088, 32'h5a);
    rdc("gpr a2", 12'h288, 32'h5a);
    rdc("status", 12'h00c, 32'h38);
    rdc("status b1", 12'h20c, 32'h38);
    rdc("run bit", 12'h400, 32'h1);
    apb(1'b1, 12'h02c, 32'h40);
    rdc("intctl b1", 12'h22c, 32'h40);
    apb(1'b1, 12'h01c, 32'h77);
    rdc("unimpl 07", 12'h01c, 32'h0);
    rdc("unimpl b0", 12'h2c0, 32'h0);
    apb(1'b1, 12'h0bc, 32'h11);
    rdc("gpr top", 12'h0bc, 32'h11);
    apb(1'b1, 12'h0c0, 32'h22);
    rdc("above top", 12'h0c0, 32'h0);
    apb(1'b1, 12'h010, 32'ha1);
    rdc("indirect", 12'h000, 32'h5a);
    apb(1'b1, 12'h010, 32'h80);
    rdc("ind zero", 12'h000, 32'h0);
    apb(1'b0, 12'h40c, 32'h0);
    chk("slverr", {31'h0, err}, 32'h1);
    // Halt lands on the phase-three edge, so rotation stops on phase four
    apb(1'b1, 12'h400, 32'h0);
    repeat (4) @(posedge ref_clk);
    chk("halt phase", {28'h0, phase}, 32'h8);
    pa = prog_addr;
    repeat (8) @(posedge ref_clk);
    chk("halt addr", {19'h0, prog_addr}, {19'h0, pa});
    rdc("halt run", 12'h400, 32'h0);
    rdc("halt wreg", 12'h408, 32'h5a);
    apb(1'b1, 12'h400, 32'h1);
    repeat (2) @(posedge ref_clk);
    chk("resume phase", {28'h0, phase}, 32'h1);
    irq_event <= 8'h08;
    @(posedge ref_clk);
    irq_event <= 8'h00;
    rdc("flags", 12'h030, 32'h08);
    rdc("flags b1", 12'h230, 32'h08);
    // Event held across a bus clear: the set must win
    irq_event <= 8'h01;
    apb(1'b1, 12'h030, 32'h0);
    irq_event <= 8'h00;
    rdc("flags set wins", 12'h030, 32'h01);
    // Stale flag cleared before the global enable is set
    apb(1'b1, 12'h030, 32'h0);
    rdc("flags clr", 12'h030, 32'h0);
    apb(1'b1, 12'h02c, 32'hc0);
    rdc("intctl en", 12'h02c, 32'hc0);
    stop_test;
  end

  initial
  begin
    repeat (3000) @(posedge ref_clk);
    n_errors++;
    stop_test;
  end
endmodule
`default_nettype wire
